/* File: include/tdm_code_consts.svh */
`ifndef TDM_CODE_CONSTS_SVH
`define TDM_CODE_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define QFR_PAGE 10'h012
`define CMH_PAGE 2'h2
`define QFR_W 12
`define QFR_RST 12'h000
`define CMH_TOP 4
`define CMH_RST 5'h00

// ****************************************
// Quadrant code fields
// ****************************************
`define QCODE_W 3
`define QC_ACT 2
`define QC_MSB 1
`define QC_VAL 0

// ****************************************
// Coding law masks and companding figures
// ****************************************
`define MSK_NONE 8'h00
`define MSK_EVEN 8'h55
`define MSK_ODD 8'hAA
`define MSK_ALL 8'hFF
`define MSK_SIGN 8'h80
`define MU_BIAS 16'h0084
`define MU_CLIP 16'h7F7B
`define A_OFS 16'h0108

// ****************************************
// Output buffer
// ****************************************
`define FIFO_SLACK 4

`endif

/* File: include/tdm_code_pkg.sv */
`default_nettype none

package tdm_code_pkg;

	typedef struct packed {
		logic [3:0] stream;
		logic [7:0] chan;
		logic [7:0] data;
	} in_byte_type;

	typedef struct packed {
		logic vd;
		logic [1:0] icl;
		logic [1:0] ocl;
	} cmh_type;

	typedef logic [1:0] rate_type;

endpackage : tdm_code_pkg

`default_nettype wire

/* File: src/chan_fifo.sv */
`default_nettype none

module chan_fifo #(
	parameter int W = 8,
	parameter int D = 16,
	parameter int AW = $clog2(D)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out,
	output logic [AW:0] level_out
);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] wp_nxt;
	logic [AW-1:0] rp_r;
	logic [AW-1:0] rp_nxt;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;

	always_comb begin
		in_ready_out = (cnt_r != (AW+1)'(D));
		out_valid_out = (cnt_r != '0);
		out_data_out = mem[rp_r];
		level_out = cnt_r;
		push = ce_in && in_valid_in && in_ready_out;
		pop = ce_in && out_valid_out && out_ready_in;
		wp_nxt = push ? AW'((wp_r + 1'b1) % D) : wp_r;
		rp_nxt = pop ? AW'((rp_r + 1'b1) % D) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wp_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

endmodule : chan_fifo

`default_nettype wire

/* File: src/cmh_mem.sv */
`default_nettype none

module cmh_mem #(
	parameter int AW = 12,
	parameter int DW = 5
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic we_in,
	input wire logic [AW-1:0] wa_in,
	input wire logic [DW-1:0] wd_in,
	input wire logic [AW-1:0] ra0_in,
	output logic [DW-1:0] rd0_out,
	input wire logic [AW-1:0] ra1_in,
	output logic [DW-1:0] rd1_out
);

	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rd0_nxt;
	logic [DW-1:0] rd1_nxt;

	always_comb begin
		rd0_nxt = ce_in ? mem[ra0_in] : rd0_out;
		rd1_nxt = ce_in ? mem[ra1_in] : rd1_out;
	end

	// Storage has no reset; software fills it before use.
	always_ff @(posedge clk_in) begin
		if (ce_in && we_in) begin
			mem[wa_in] <= wd_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd0_out <= '0;
			rd1_out <= '0;
		end else begin
			rd0_out <= rd0_nxt;
			rd1_out <= rd1_nxt;
		end
	end

endmodule : cmh_mem

`default_nettype wire

/* File: src/tdm_channel_code_translate.sv */
`include "tdm_code_consts.svh"
`default_nettype none

// Function
// - Connection memory high word bit 4 picks voice (0) or data (1) coding.
// - Same word: input law in bits 3-2, output law in bits 1-0.
// - Voice code 00 is standard A-law, 01 is standard mu-law.
// - Voice code 10 is A-law with even bits left uninverted.
// - Voice code 11 is mu-law with magnitude bits left uninverted.
// - Data code 00 inverts no bit.
// - Data code 01 inverts bits 6, 4, 2 and 0.
// - Data code 10 inverts bits 7, 5, 3 and 1.
// - Data code 11 inverts all eight bits.
// - Differing input and output laws translate the byte; laws set independently.
// - Equal input and output laws pass the byte unchanged.
// - One selector per channel, so voice never translates to data.
// - Translation covers switched bytes and message-mode bytes alike.
// - Each input frame splits into four equal consecutive channel quadrants per rate.
// - Quadrant codes sit at bits 11-9, 8-6, 5-3 and 2-0.
// - Code 0xx leaves data; 100 forces LSB to 0, 101 to 1.
// - Code 110 forces MSB to 0, code 111 forces MSB to 1.
// - Sixteen independent quadrant registers, one per input stream.
// - Connection high reads give bits 4-0, zeros above; writes ignore bits 15-5.
module tdm_channel_code_translate #(
	parameter int STREAMS = 16,
	parameter int CM_AW = 12,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic CS_N_IN,
	input wire logic RD_N_IN,
	input wire logic WR_N_IN,
	input wire logic [13:0] ADDR_IN,
	input wire logic [15:0] D_IN,
	output logic [15:0] D_OUT,
	output logic D_OE_OUT,
	output logic RDY_OUT,
	input wire logic IN_VALID_IN,
	input wire tdm_code_pkg::in_byte_type IN_DATA_IN,
	input wire tdm_code_pkg::rate_type IN_RATE_IN,
	output logic FORCED_VALID_OUT,
	output var tdm_code_pkg::in_byte_type FORCED_OUT,
	input wire logic SW_VALID_IN,
	input wire logic [CM_AW-1:0] SW_ADDR_IN,
	input wire logic SW_MSG_IN,
	input wire logic [7:0] SW_BYTE_IN,
	input wire logic [7:0] MSG_BYTE_IN,
	output logic SW_READY_OUT,
	output logic OUT_VALID_OUT,
	output logic [7:0] OUT_BYTE_OUT,
	input wire logic OUT_READY_IN
);

	// ****************************************
	// Decoding and coding functions
	// ****************************************
	function automatic logic is_qfr(input logic [13:0] a);
		return a[13:4] == `QFR_PAGE;
	endfunction : is_qfr

	function automatic logic is_cmh(input logic [13:0] a);
		return a[13:12] == `CMH_PAGE;
	endfunction : is_cmh

	function automatic logic [7:0] law_mask(input logic vd, input logic [1:0] law);
		logic [7:0] m;
		m = `MSK_NONE;
		if (vd) begin
			case (law)
				2'h0: m = `MSK_NONE;
				2'h1: m = `MSK_EVEN;
				2'h2: m = `MSK_ODD;
				default: m = `MSK_ALL;
			endcase
		end else begin
			case (law)
				2'h0: m = `MSK_EVEN;
				2'h1: m = `MSK_ALL;
				2'h2: m = `MSK_NONE;
				default: m = `MSK_SIGN;
			endcase
		end
		return m;
	endfunction : law_mask

	// Sign-magnitude byte to sign and linear magnitude.
	function automatic logic [16:0] raw_to_lin(input logic [7:0] raw, input logic mu);
		logic [15:0] mag;
		mag = {8'h00, raw[3:0], 4'h0};
		if (mu) begin
			mag = (({9'h000, raw[3:0], 3'h0} + `MU_BIAS) << raw[6:4]) - `MU_BIAS;
		end else if (raw[6:4] == 3'h0) begin
			mag = {8'h00, raw[3:0], 4'h8};
		end else begin
			mag = (mag + `A_OFS) << (raw[6:4] - 3'h1);
		end
		return {mu ? raw[7] : ~raw[7], mag};
	endfunction : raw_to_lin

	function automatic logic [7:0] lin_to_raw(input logic [16:0] lin, input logic mu);
		logic [15:0] v;
		logic [15:0] sh;
		logic [2:0] e;
		v = lin[15:0];
		e = 3'h0;
		if (mu) begin
			if (v > `MU_CLIP) begin
				v = `MU_CLIP;
			end
			v = v + `MU_BIAS;
		end
		for (int i = 1; i < 8; i++) begin
			if (v[i+7]) begin
				e = 3'(i);
			end
		end
		sh = (!mu && e == 3'h0) ? (v >> 1) : (v >> e);
		return {mu ? lin[16] : ~lin[16], e, sh[6:3]};
	endfunction : lin_to_raw

	// Law changes between the A and mu families go through a linear value,
	// which trades exact table equality at a few codes for a small design.
	function automatic logic [7:0] translate(input logic [7:0] x, input tdm_code_pkg::cmh_type c);
		logic [7:0] raw;
		raw = x ^ law_mask(c.vd, c.icl);
		if (c.icl == c.ocl) begin
			return x;
		end
		if (!c.vd && (c.icl[0] != c.ocl[0])) begin
			raw = lin_to_raw(raw_to_lin(raw, c.icl[0]), c.ocl[0]);
		end
		return raw ^ law_mask(c.vd, c.ocl);
	endfunction : translate

	function automatic logic [1:0] quad_of(input logic [7:0] ch, input tdm_code_pkg::rate_type r);
		logic [1:0] q;
		case (r)
			2'h0: q = ch[4:3];
			2'h1: q = ch[5:4];
			2'h2: q = ch[6:5];
			default: q = ch[7:6];
		endcase
		return q;
	endfunction : quad_of

	function automatic logic [7:0] apply_force(input logic [7:0] d, input logic [2:0] code);
		logic [7:0] r;
		r = d;
		if (code[`QC_ACT]) begin
			if (code[`QC_MSB]) begin
				r[7] = code[`QC_VAL];
			end else begin
				r[0] = code[`QC_VAL];
			end
		end
		return r;
	endfunction : apply_force

	// ****************************************
	// Microprocessor port
	// ****************************************
	// Strobes, address and data are pins, so each bit is filtered
	// by four flip-flops before anything decodes it.
	logic [32:0] pin_s1_r;
	logic [32:0] pin_s2_r;
	logic [32:0] pin_s3_r;
	logic [32:0] filt_r;
	logic [32:0] filt_nxt;
	logic [13:0] wa_r;
	logic [13:0] wa_nxt;
	logic [15:0] wd_r;
	logic [15:0] wd_nxt;
	logic act_prev_r;
	logic wr_prev_r;
	logic [15:0] d_out_nxt;
	logic rdy_nxt;
	logic [`QFR_W-1:0] qfr_r [STREAMS];
	logic [`QFR_W-1:0] qfr_nxt [STREAMS];
	logic rd_act;
	logic wr_act;
	logic wr_done;
	logic [4:0] cm_rd1;
	logic [15:0] rmux;

	always_comb begin
		filt_nxt = (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (filt_r & (pin_s2_r ^ pin_s3_r));
		rd_act = filt_r[32] && filt_r[31];
		wr_act = filt_r[32] && filt_r[30];
		wr_done = wr_prev_r && !wr_act;
		wa_nxt = wr_act ? filt_r[29:16] : wa_r;
		wd_nxt = wr_act ? filt_r[15:0] : wd_r;
		rmux = 16'h0000;
		if (is_qfr(filt_r[29:16])) begin
			rmux = {4'h0, qfr_r[filt_r[19:16]]};
		end else if (is_cmh(filt_r[29:16])) begin
			rmux = {11'h000, cm_rd1};
		end
		d_out_nxt = rd_act ? rmux : 16'h0000;
		rdy_nxt = (rd_act || wr_act) && act_prev_r;
		for (int i = 0; i < STREAMS; i++) begin
			qfr_nxt[i] = qfr_r[i];
			if (wr_done && is_qfr(wa_r) && (wa_r[3:0] == 4'(i))) begin
				qfr_nxt[i] = wd_r[`QFR_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			filt_r <= '0;
			wa_r <= 14'h0000;
			wd_r <= 16'h0000;
			act_prev_r <= 1'b0;
			wr_prev_r <= 1'b0;
			D_OUT <= 16'h0000;
			D_OE_OUT <= 1'b0;
			RDY_OUT <= 1'b0;
			for (int i = 0; i < STREAMS; i++) begin
				qfr_r[i] <= `QFR_RST;
			end
		end else if (CE_IN) begin
			pin_s1_r <= {~CS_N_IN, ~RD_N_IN, ~WR_N_IN, ADDR_IN, D_IN};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			filt_r <= filt_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			act_prev_r <= rd_act || wr_act;
			wr_prev_r <= wr_act;
			D_OUT <= d_out_nxt;
			D_OE_OUT <= rd_act;
			RDY_OUT <= rdy_nxt;
			qfr_r <= qfr_nxt;
		end
	end

	// ****************************************
	// Input side quadrant forcing
	// ****************************************
	logic [1:0] in_quad;
	logic [2:0] in_code;
	tdm_code_pkg::in_byte_type forced_nxt;

	always_comb begin
		in_quad = quad_of(IN_DATA_IN.chan, IN_RATE_IN);
		in_code = qfr_r[IN_DATA_IN.stream][{2'h0, in_quad} * 4'h3 +: `QCODE_W];
		forced_nxt = IN_DATA_IN;
		forced_nxt.data = apply_force(IN_DATA_IN.data, in_code);
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			FORCED_VALID_OUT <= 1'b0;
			FORCED_OUT <= '0;
		end else if (CE_IN) begin
			FORCED_VALID_OUT <= IN_VALID_IN;
			FORCED_OUT <= forced_nxt;
		end
	end

	// ****************************************
	// Output side law translation
	// ****************************************
	tdm_code_pkg::cmh_type cmh;
	logic [4:0] cm_rd0;
	logic s1_valid_r;
	logic [7:0] s1_byte_r;
	logic [7:0] s1_byte_nxt;
	logic s2_valid_r;
	logic [7:0] s2_byte_r;
	logic [7:0] s2_byte_nxt;
	logic accept;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic pop;
	logic ready_nxt;
	logic ov_nxt;
	logic [7:0] ob_nxt;

	cmh_mem #(
		.AW(CM_AW),
		.DW(`CMH_TOP + 1)
	) u_cmh (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.we_in(wr_done && is_cmh(wa_r)),
		.wa_in(wa_r[CM_AW-1:0]),
		.wd_in(wd_r[`CMH_TOP:0]),
		.ra0_in(SW_ADDR_IN),
		.rd0_out(cm_rd0),
		.ra1_in(filt_r[CM_AW+15:16]),
		.rd1_out(cm_rd1)
	);

	chan_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.in_valid_in(s2_valid_r),
		.in_data_in(s2_byte_r),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(fifo_valid),
		.out_ready_in(!OUT_VALID_OUT || OUT_READY_IN),
		.out_data_out(fifo_data),
		.level_out(fifo_level)
	);

	always_comb begin
		cmh = cm_rd0;
		accept = SW_VALID_IN && SW_READY_OUT;
		s1_byte_nxt = SW_MSG_IN ? MSG_BYTE_IN : SW_BYTE_IN;
		s2_byte_nxt = translate(s1_byte_r, cmh);
		ready_nxt = int'(fifo_level) <= FIFO_DEPTH - `FIFO_SLACK;
		pop = fifo_valid && (!OUT_VALID_OUT || OUT_READY_IN);
		ov_nxt = pop || (OUT_VALID_OUT && !OUT_READY_IN);
		ob_nxt = pop ? fifo_data : OUT_BYTE_OUT;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s1_valid_r <= 1'b0;
			s1_byte_r <= 8'h00;
			s2_valid_r <= 1'b0;
			s2_byte_r <= 8'h00;
			SW_READY_OUT <= 1'b0;
			OUT_VALID_OUT <= 1'b0;
			OUT_BYTE_OUT <= 8'h00;
		end else if (CE_IN) begin
			s1_valid_r <= accept;
			s1_byte_r <= s1_byte_nxt;
			s2_valid_r <= s1_valid_r;
			s2_byte_r <= s2_byte_nxt;
			SW_READY_OUT <= ready_nxt;
			OUT_VALID_OUT <= ov_nxt;
			OUT_BYTE_OUT <= ob_nxt;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	a_lsb_force_zero: assert property (CE_IN && IN_VALID_IN && in_code == 3'h4 |=>
		FORCED_VALID_OUT && FORCED_OUT.data[0] == 1'b0)
		else $error("LSB not forced to zero.");
	a_lsb_force_one: assert property (CE_IN && IN_VALID_IN && in_code == 3'h5 |=>
		FORCED_OUT.data == {$past(IN_DATA_IN.data[7:1]), 1'b1})
		else $error("LSB not forced to one.");
	a_msb_force_val: assert property (CE_IN && IN_VALID_IN && in_code[2:1] == 2'h3 |=>
		FORCED_OUT.data == {$past(in_code[0]), $past(IN_DATA_IN.data[6:0])})
		else $error("MSB force value wrong.");
	a_quad_normal_op: assert property (CE_IN && !in_code[2] |=>
		FORCED_OUT.data == $past(IN_DATA_IN.data))
		else $error("Untouched quadrant altered.");
	a_same_law_pass: assert property (CE_IN && s1_valid_r && cmh.icl == cmh.ocl |=>
		s2_byte_r == $past(s1_byte_r))
		else $error("Equal laws changed the byte.");
	a_data_all_inv: assert property (CE_IN && cmh == 5'h13 |=>
		s2_byte_r == ~$past(s1_byte_r))
		else $error("All-bit inversion wrong.");
	a_data_even_inv: assert property (CE_IN && cmh == 5'h11 |=>
		s2_byte_r == ($past(s1_byte_r) ^ 8'h55))
		else $error("Even-bit inversion wrong.");
	a_data_odd_inv: assert property (CE_IN && cmh == 5'h12 |=>
		s2_byte_r == ($past(s1_byte_r) ^ 8'hAA))
		else $error("Odd-bit inversion wrong.");
	a_voice_abi_off: assert property (CE_IN && cmh == 5'h02 |=>
		s2_byte_r == ($past(s1_byte_r) ^ 8'h55))
		else $error("A-law variant mask wrong.");
	a_cmh_read_zero: assert property (CE_IN && rd_act && is_cmh(filt_r[29:16]) |=>
		D_OE_OUT && D_OUT[15:5] == 11'h000)
		else $error("Upper data lines not zero.");
	a_qfr_write_back: assert property (CE_IN && wr_done && is_qfr(wa_r) |=>
		qfr_r[$past(wa_r[3:0])] == $past(wd_r[11:0]))
		else $error("Quadrant register not written.");
	a_fifo_no_drop: assert property (s2_valid_r |-> fifo_in_ready)
		else $error("Translated byte dropped.");

endmodule : tdm_channel_code_translate

`default_nettype wire

/* File: testbench/tdm_out_sink.sv */
`default_nettype none

// ****************************************
// Output sink model
// ****************************************
module tdm_out_sink (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic valid_in,
	input wire logic [7:0] byte_in,
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt;
	logic [7:0] got[$];
	initial begin
		cnt = 2'h0;
		ready_out = 1'b0;
	end
	// Slow mode takes one byte in four, so the buffer fills and refuses.
	always @(negedge clk_in) begin
		cnt <= cnt + 2'h1;
		ready_out <= !rst_in && (!slow_in || cnt == 2'h3);
	end
	always @(posedge clk_in) begin
		if (valid_in === 1'b1 && ready_out) begin
			got.push_back(byte_in);
		end
	end
endmodule : tdm_out_sink

`default_nettype wire

/* File: testbench/test_tdm_channel_code_translate.sv */
`default_nettype none

module test_tdm_channel_code_translate;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Signals
	// ****************************************
	logic CLK_IN, RST_IN, CE_IN, CS_N_IN, RD_N_IN, WR_N_IN;
	logic [13:0] ADDR_IN;
	logic [15:0] D_IN, D_OUT;
	logic D_OE_OUT, RDY_OUT, IN_VALID_IN, FORCED_VALID_OUT;
	tdm_code_pkg::in_byte_type IN_DATA_IN, FORCED_OUT;
	tdm_code_pkg::rate_type IN_RATE_IN;
	logic SW_VALID_IN, SW_MSG_IN, SW_READY_OUT, OUT_VALID_OUT, OUT_READY_IN, slow;
	logic [11:0] SW_ADDR_IN;
	logic [7:0] SW_BYTE_IN, MSG_BYTE_IN, OUT_BYTE_OUT;
	int bad_count, cmp_count;
	logic [7:0] expq[$];

	tdm_channel_code_translate u_tdm_channel_code_translate (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
		.CE_IN(CE_IN), .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN),
		.ADDR_IN(ADDR_IN), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_OUT(D_OE_OUT), .RDY_OUT(RDY_OUT),
		.IN_VALID_IN(IN_VALID_IN), .IN_DATA_IN(IN_DATA_IN), .IN_RATE_IN(IN_RATE_IN),
		.FORCED_VALID_OUT(FORCED_VALID_OUT), .FORCED_OUT(FORCED_OUT),
		.SW_VALID_IN(SW_VALID_IN), .SW_ADDR_IN(SW_ADDR_IN), .SW_MSG_IN(SW_MSG_IN),
		.SW_BYTE_IN(SW_BYTE_IN), .MSG_BYTE_IN(MSG_BYTE_IN), .SW_READY_OUT(SW_READY_OUT),
		.OUT_VALID_OUT(OUT_VALID_OUT), .OUT_BYTE_OUT(OUT_BYTE_OUT), .OUT_READY_IN(OUT_READY_IN));

	tdm_out_sink u_tdm_out_sink (.clk_in(CLK_IN), .rst_in(RST_IN), .slow_in(slow),
		.valid_in(OUT_VALID_OUT), .byte_in(OUT_BYTE_OUT), .ready_out(OUT_READY_IN));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Strobes stay put at least six cycles and until the acknowledge is seen.
	task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		ADDR_IN = a;
		D_IN = wr ? d : ~D_IN;
		CS_N_IN = 1'b0;
		WR_N_IN = !wr;
		RD_N_IN = wr;
		do begin
			@(negedge CLK_IN);
			n++;
		end while (!(RDY_OUT === 1'b1 && n >= 6) && n < 40);
		chk({15'h0, RDY_OUT}, 16'h0001, "acknowledge");
		if (!wr) begin
			chk({15'h0, D_OE_OUT}, 16'h0001, "bus drive");
		end else begin
			chk({15'h0, D_OE_OUT}, 16'h0000, "bus idle on write");
		end
		q = D_OUT;
		CS_N_IN = 1'b1;
		WR_N_IN = 1'b1;
		RD_N_IN = 1'b1;
		n = 0;
		while (RDY_OUT !== 1'b0 && n < 20) begin
			@(negedge CLK_IN);
			n++;
		end
		repeat (5) @(negedge CLK_IN);
	endtask : acc

	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		logic [15:0] q;
		acc(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [13:0] a, input logic [15:0] exp);
		logic [15:0] q;
		acc(1'b0, a, 16'h0000, q);
		chk(q, exp, "register read");
	endtask : rd

	function automatic logic [7:0] frc(input logic [2:0] c, input logic [7:0] d);
		case (c)
			3'h4: frc = {d[7:1], 1'b0};
			3'h5: frc = {d[7:1], 1'b1};
			3'h6: frc = {1'b0, d[6:0]};
			3'h7: frc = {1'b1, d[6:0]};
			default: frc = d;
		endcase
	endfunction : frc

	function automatic logic [7:0] msk(input logic vd, input logic [1:0] c);
		logic [7:0] dm[4];
		logic [7:0] vm[4];
		dm = '{8'h00, 8'h55, 8'hAA, 8'hFF};
		vm = '{8'h55, 8'hFF, 8'h00, 8'h80};
		msk = vd ? dm[c] : vm[c];
	endfunction : msk

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		CLK_IN = 1'b0;
		forever #5 CLK_IN = ~CLK_IN;
	end

	initial begin
		repeat (20000) @(posedge CLK_IN);
		bad_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		logic [11:0] qf[2];
		logic [7:0] dv, b;
		logic [7:0] ch;
		logic [4:0] k;
		logic saw_full;
		int n;
		RST_IN = 1'b1; CE_IN = 1'b1; CS_N_IN = 1'b1; RD_N_IN = 1'b1; WR_N_IN = 1'b1;
		ADDR_IN = 14'h0000; D_IN = 16'h0000; IN_VALID_IN = 1'b0; IN_DATA_IN = '0;
		IN_RATE_IN = 2'h0; SW_VALID_IN = 1'b0; SW_ADDR_IN = 12'h000; SW_MSG_IN = 1'b0;
		SW_BYTE_IN = 8'h00; MSG_BYTE_IN = 8'h00; slow = 1'b0; saw_full = 1'b0;
		bad_count = 0; cmp_count = 0;
		repeat (2) @(posedge CLK_IN);
		@(negedge CLK_IN);
		RST_IN = 1'b0;
		repeat (3) @(negedge CLK_IN);
		rd(14'h0120, 16'h0000);
		rd(14'h012F, 16'h0000);
		wr(14'h1000, 16'hFFFF);
		rd(14'h1000, 16'h0000);
		// Bit error reception is never enabled here, so forcing is legal on any stream.
		qf = '{12'hFAC, 12'h6DB};
		wr(14'h0123, {4'hF, qf[0]});
		wr(14'h0124, {4'h0, qf[1]});
		rd(14'h0123, {4'h0, qf[0]});
		rd(14'h0124, {4'h0, qf[1]});
		for (int s = 0; s < 2; s++) begin
			for (int r = 0; r < 4; r++) begin
				for (int y = 0; y < 4; y++) begin
					for (int e = 0; e < 2; e++) begin
						dv = e ? 8'hFF : 8'h00;
						ch = 8'(y << (3 + r)) + (e ? 8'((1 << (3 + r)) - 1) : 8'h00);
						IN_RATE_IN = 2'(r);
						IN_DATA_IN = '{stream: 4'(3 + s), chan: ch, data: dv};
						IN_VALID_IN = 1'b1;
						@(negedge CLK_IN);
						chk({15'h0, FORCED_VALID_OUT}, 16'h0001, "forced valid");
						chk({4'h0, FORCED_OUT.stream, FORCED_OUT.chan}, {4'h0, 4'(3 + s), ch},
							"forced chan");
						chk({8'h00, FORCED_OUT.data}, {8'h00, frc(qf[s][3*y+:3], dv)},
							"forced data");
					end
				end
			end
		end
		IN_VALID_IN = 1'b0;
		CE_IN = 1'b0;
		IN_DATA_IN.data = 8'h5A;
		repeat (3) @(negedge CLK_IN);
		chk({8'h00, FORCED_OUT.data}, 16'h00FF, "frozen byte");
		chk({15'h0, FORCED_VALID_OUT}, 16'h0001, "frozen valid");
		CE_IN = 1'b1;
		for (int j = 0; j < 32; j++) begin
			k = 5'(j);
			if (k[4] || k[2] == k[0] || j == 1 || j == 4) begin
				wr(14'h2000 + 14'(j), {11'h7FF, k});
				rd(14'h2000 + 14'(j), {11'h000, k});
			end
		end
		slow = 1'b1;
		for (int j = 0; j < 32; j++) begin
			k = 5'(j);
			if (k[4] || k[2] == k[0] || j == 1 || j == 4) begin
				b = (j == 1) ? 8'hFA : (j == 4) ? 8'hFF : 8'(j * 37 + 5);
				SW_ADDR_IN = 12'(j);
				SW_MSG_IN = k[0];
				SW_BYTE_IN = k[0] ? ~b : b;
				MSG_BYTE_IN = k[0] ? b : ~b;
				SW_VALID_IN = 1'b1;
				// Cross-family voice codes take their expected bytes from the companding tables.
				if (j == 1) begin
					expq.push_back(8'hCE);
				end else if (j == 4) begin
					expq.push_back(8'hD5);
				end else begin
					expq.push_back(b ^ msk(k[4], k[3:2]) ^ msk(k[4], k[1:0]));
				end
				n = 0;
				while (SW_READY_OUT !== 1'b1 && n < 100) begin
					saw_full = 1'b1;
					@(negedge CLK_IN);
					n++;
				end
				@(negedge CLK_IN);
			end
		end
		SW_VALID_IN = 1'b0;
		chk({15'h0, saw_full}, 16'h0001, "buffer refusal");
		slow = 1'b0;
		n = 0;
		while (u_tdm_out_sink.got.size() < expq.size() && n < 300) begin
			@(negedge CLK_IN);
			n++;
		end
		chk(16'(u_tdm_out_sink.got.size()), 16'(expq.size()), "byte count");
		foreach (expq[i]) begin
			b = (i < u_tdm_out_sink.got.size()) ? u_tdm_out_sink.got[i] : 8'hXX;
			chk({8'h00, b}, {8'h00, expq[i]}, "translated byte");
		end
		end_sim();
	end
endmodule : test_tdm_channel_code_translate

`default_nettype wire
